// ### pkg/csw_regs.vh
// Purpose: Register map, field positions, keys and counts of the clock switch block
// Assumes: Included by csw_ctrl and by the property checker of the clock switch block
// Notes:   Byte offsets on a 32-bit classic Wishbone bus
`ifndef CSW_REGS_VH
`define CSW_REGS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define CSW_ADR_OSC       4'h0
`define CSW_ADR_REF       4'h4
`define CSW_ADR_STAT      4'h8

// ---------------------------------------------------------------
// Oscillator control fields
// ---------------------------------------------------------------
`define CSW_OSC_CUR_HI    14
`define CSW_OSC_CUR_LO    12
`define CSW_OSC_NEW_HI    10
`define CSW_OSC_NEW_LO    8
`define CSW_OSC_SELLOCK   7
`define CSW_OSC_LOCK      5
`define CSW_OSC_CF        3
`define CSW_OSC_PSLP      2
`define CSW_OSC_SECONDARY_OSC_ENABLE    1
`define CSW_OSC_REQ       0

// ---------------------------------------------------------------
// Reference control fields
// ---------------------------------------------------------------
`define CSW_REF_EN        15
`define CSW_REF_SLP       13
`define CSW_REF_SEL       12
`define CSW_REF_DIV_HI    11
`define CSW_REF_DIV_LO    8
`define CSW_REF_RST       4'h0

// ---------------------------------------------------------------
// Unlock keys
// ---------------------------------------------------------------
`define CSW_KEY_HI1       8'h78
`define CSW_KEY_HI2       8'h9a
`define CSW_KEY_LO1       8'h46
`define CSW_KEY_LO2       8'h57

// ---------------------------------------------------------------
// Source codes
// ---------------------------------------------------------------
`define CSW_SRC_FRC       3'h0
`define CSW_SRC_FAST_RC_WITH_PLL    3'h1
`define CSW_SRC_PRI       3'h2
`define CSW_SRC_PRIPLL    3'h3
`define CSW_SRC_SEC       3'h4
`define CSW_SRC_LOW_POWER_RC      3'h5

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CSW_SETTLE_CYCLES 4'ha

`endif

// ### core/csw_ref_div.v
// Purpose: Power-of-two divider for the reference clock output
// Assumes: Base clock level is sampled synchronously to clk_i
// Notes:   Code 0 passes the sampled base level straight through
`timescale 1ns/1ps
module csw_ref_div (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        base_i,
   input  wire [3:0]  div_i,
   input  wire        run_i,
   output reg         out_o
);

   reg        base_q;
   reg [13:0] cnt;
   wire       rise;

   // ---------------------------------------------------------------
   // Half-period limit in base rising edges
   // ---------------------------------------------------------------
   function [13:0] half_limit;
      input [3:0] code;
      reg   [14:0] one_hot;
      begin
         one_hot    = 15'h0001 << (code - 4'h1);
         half_limit = one_hot[13:0] - 14'h0001;
      end
   endfunction

   assign rise = base_i & ~base_q;

   always @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         base_q <= 1'b0;
         cnt    <= 14'h0000;
         out_o  <= 1'b0;
      end else begin
         base_q <= base_i;
         if (div_i == 4'h0) begin
            out_o <= base_i;
            cnt   <= 14'h0000;
         end else if (rise) begin
            if (cnt >= half_limit(div_i)) begin
               cnt   <= 14'h0000;
               out_o <= ~out_o;
            end else begin
               cnt <= cnt + 14'h0001;
            end
         end
      end
   end

endmodule // csw_ref_div

// ### core/csw_ctrl.v
// Purpose: Clock source switch controller with reference clock output
// Assumes: Oscillator status, ticks and base clock levels arrive synchronous to clk_i
// Notes:   Registers reached over classic Wishbone, 32-bit data, one-cycle ack
`timescale 1ns/1ps
`include "csw_regs.vh"

module csw_ctrl (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        switch_config_bit_i,
   input  wire [2:0]  config_initial_source_i,
   input  wire        failsafe_monitor_en_i,
   input  wire        watchdog_en_i,
   input  wire        clock_fail_i,
   input  wire [7:0]  osc_ready_i,
   input  wire        pll_lock_i,
   input  wire        new_clk_tick_i,
   input  wire        sleep_i,
   input  wire        primary_clk_i,
   input  wire        system_clk_i,
   output reg  [2:0]  sys_src_sel_o,
   output reg  [7:0]  osc_enable_o,
   output reg         switch_busy_o,
   output reg         ref_clock_pin_o
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   localparam S_IDLE  = 3'd0;
   localparam S_CHECK = 3'd1;
   localparam S_OSC   = 3'd2;
   localparam S_PLL   = 3'd3;
   localparam S_CNT   = 3'd4;

   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [2:0]  current_source_sel;
   reg  [2:0]  new_source_sel;
   reg  [2:0]  target;
   reg         switch_request;
   reg         selection_lock;
   reg         lock_flag;
   reg         clock_fail_flag;
   reg         primary_sleep_enable;
   reg         secondary_osc_enable;
   reg         ref_out_enable;
   reg         ref_run_in_sleep;
   reg         ref_source_select;
   reg  [3:0]  ref_divisor;
   reg  [1:0]  hi_stage;
   reg  [1:0]  lo_stage;
   reg  [3:0]  settle_cnt;
   reg  [7:0]  next_osc_en;
   reg  [31:0] next_rdata;

   wire        access;
   wire        wr;
   wire        wr_osc;
   wire        hi_only;
   wire        lo_only;
   wire [7:0]  hi_byte;
   wire [7:0]  lo_byte;
   wire        switch_disabled;
   wire        req_refused;
   wire        valid_start;
   wire        handover;
   wire        ref_run;
   wire        ref_div_out;

   // ---------------------------------------------------------------
   // Source decoding
   // ---------------------------------------------------------------
   function uses_pll;
      input [2:0] code;
      begin
         uses_pll = (code == `CSW_SRC_FAST_RC_WITH_PLL) || (code == `CSW_SRC_PRIPLL);
      end
   endfunction

   function is_primary;
      input [2:0] code;
      begin
         is_primary = (code == `CSW_SRC_PRI) || (code == `CSW_SRC_PRIPLL);
      end
   endfunction

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   assign access          = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr              = access & wb_we_i;
   assign wr_osc          = wr & (wb_adr_i == `CSW_ADR_OSC);
   assign hi_only         = wb_sel_i[1] & ~wb_sel_i[0];
   assign lo_only         = wb_sel_i[0] & ~wb_sel_i[1];
   assign hi_byte         = wb_dat_i[15:8];
   assign lo_byte         = wb_dat_i[7:0];
   assign switch_disabled = switch_config_bit_i;
   assign req_refused     = failsafe_monitor_en_i & selection_lock;
   assign valid_start     = (state == S_CHECK) && (target != current_source_sel);
   assign handover        = (state == S_CNT) && new_clk_tick_i &&
                            (settle_cnt == `CSW_SETTLE_CYCLES - 4'h1);

   // ---------------------------------------------------------------
   // Bus slave: one-cycle ack, never stalls the processor
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= access;
         if (access) begin
            wb_dat_o <= next_rdata;
         end
      end
   end

   always @* begin
      next_rdata = 32'h00000000;
      case (wb_adr_i)
         `CSW_ADR_OSC: begin
            next_rdata[`CSW_OSC_CUR_HI:`CSW_OSC_CUR_LO] = current_source_sel;
            next_rdata[`CSW_OSC_NEW_HI:`CSW_OSC_NEW_LO] = new_source_sel;
            next_rdata[`CSW_OSC_SELLOCK]                = selection_lock;
            next_rdata[`CSW_OSC_LOCK]                   = lock_flag;
            next_rdata[`CSW_OSC_CF]                     = clock_fail_flag;
            next_rdata[`CSW_OSC_PSLP]                   = primary_sleep_enable;
            next_rdata[`CSW_OSC_SECONDARY_OSC_ENABLE]                 = secondary_osc_enable;
            next_rdata[`CSW_OSC_REQ]                    = switch_request;
         end
         `CSW_ADR_REF: begin
            next_rdata[`CSW_REF_EN]                     = ref_out_enable;
            next_rdata[`CSW_REF_SLP]                    = ref_run_in_sleep;
            next_rdata[`CSW_REF_SEL]                    = ref_source_select;
            next_rdata[`CSW_REF_DIV_HI:`CSW_REF_DIV_LO] = ref_divisor;
         end
         `CSW_ADR_STAT: begin
            next_rdata[2:0] = state;
            next_rdata[6:4] = target;
         end
         default: begin
            next_rdata = 32'h00000000;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Unlock sequences: any other access closes the window
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         hi_stage <= 2'd0;
         lo_stage <= 2'd0;
      end else if (access) begin
         hi_stage <= 2'd0;
         lo_stage <= 2'd0;
         if (wr_osc && hi_only) begin
            if (hi_stage == 2'd0 && hi_byte == `CSW_KEY_HI1) begin
               hi_stage <= 2'd1;
            end else if (hi_stage == 2'd1 && hi_byte == `CSW_KEY_HI2) begin
               hi_stage <= 2'd2;
            end
         end
         if (wr_osc && lo_only) begin
            if (lo_stage == 2'd0 && lo_byte == `CSW_KEY_LO1) begin
               lo_stage <= 2'd1;
            end else if (lo_stage == 2'd1 && lo_byte == `CSW_KEY_LO2) begin
               lo_stage <= 2'd2;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Switch sequencer
   // ---------------------------------------------------------------
   always @* begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (switch_request && !switch_disabled) begin
               next_state = S_CHECK;
            end
         end
         S_CHECK: begin
            if (target == current_source_sel) begin
               next_state = S_IDLE;
            end else begin
               next_state = S_OSC;
            end
         end
         S_OSC: begin
            if (osc_ready_i[target]) begin
               next_state = uses_pll(target) ? S_PLL : S_CNT;
            end
         end
         S_PLL: begin
            if (pll_lock_i) begin
               next_state = S_CNT;
            end
         end
         S_CNT: begin
            if (handover) begin
               next_state = S_IDLE;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
      if (switch_disabled) begin
         next_state = S_IDLE;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state      <= S_IDLE;
         target     <= 3'h0;
         settle_cnt <= 4'h0;
      end else begin
         state <= next_state;
         if (state == S_IDLE) begin
            target <= new_source_sel;
         end
         if (state != S_CNT) begin
            settle_cnt <= 4'h0;
         end else if (new_clk_tick_i) begin
            settle_cnt <= settle_cnt + 4'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Oscillator control register
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         current_source_sel   <= config_initial_source_i;
         new_source_sel       <= config_initial_source_i;
         switch_request       <= 1'b0;
         selection_lock       <= 1'b0;
         lock_flag            <= 1'b0;
         clock_fail_flag      <= 1'b0;
         primary_sleep_enable <= 1'b0;
         secondary_osc_enable <= 1'b0;
      end else begin
         if (wr_osc && hi_only && hi_stage == 2'd2) begin
            new_source_sel <= hi_byte[2:0];
         end
         if (wr_osc && wb_sel_i[0] && !(lo_only && lo_stage != 2'd2 &&
             ((lo_stage == 2'd0 && lo_byte == `CSW_KEY_LO1) ||
              (lo_stage == 2'd1 && lo_byte == `CSW_KEY_LO2)))) begin
            primary_sleep_enable <= lo_byte[`CSW_OSC_PSLP];
            secondary_osc_enable <= lo_byte[`CSW_OSC_SECONDARY_OSC_ENABLE];
            if (lo_byte[`CSW_OSC_SELLOCK]) begin
               selection_lock <= 1'b1;
            end
         end
         if (switch_disabled) begin
            switch_request     <= 1'b0;
            current_source_sel <= config_initial_source_i;
         end else if (wr_osc && lo_only && lo_stage == 2'd2 &&
                      lo_byte[`CSW_OSC_REQ] && !req_refused) begin
            switch_request <= 1'b1;
         end else if (state == S_CHECK && !valid_start) begin
            switch_request <= 1'b0;
         end else if (handover) begin
            switch_request     <= 1'b0;
            current_source_sel <= target;
         end
         if (valid_start || state == S_OSC) begin
            lock_flag <= 1'b0;
         end else if (state == S_PLL || state == S_CNT) begin
            lock_flag <= pll_lock_i & uses_pll(target);
         end else begin
            lock_flag <= pll_lock_i & uses_pll(current_source_sel);
         end
         if (clock_fail_i) begin
            clock_fail_flag <= 1'b1;
         end else if (valid_start) begin
            clock_fail_flag <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Reference control register
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ref_out_enable    <= 1'b0;
         ref_run_in_sleep  <= 1'b0;
         ref_source_select <= 1'b0;
         ref_divisor       <= `CSW_REF_RST;
      end else if (wr && wb_adr_i == `CSW_ADR_REF && wb_sel_i[1]) begin
         ref_out_enable    <= wb_dat_i[`CSW_REF_EN];
         ref_run_in_sleep  <= wb_dat_i[`CSW_REF_SLP];
         ref_source_select <= wb_dat_i[`CSW_REF_SEL];
         ref_divisor       <= wb_dat_i[`CSW_REF_DIV_HI:`CSW_REF_DIV_LO];
      end
   end

   // ---------------------------------------------------------------
   // Oscillator enables
   // ---------------------------------------------------------------
   always @* begin
      next_osc_en = 8'h00;
      if (!sleep_i) begin
         next_osc_en[current_source_sel] = 1'b1;
      end else if (is_primary(current_source_sel) &&
                   (primary_sleep_enable || (ref_run_in_sleep && ref_source_select))) begin
         next_osc_en[current_source_sel] = 1'b1;
      end
      if (state == S_OSC || state == S_PLL || state == S_CNT) begin
         next_osc_en[target] = 1'b1;
      end
      if (watchdog_en_i || failsafe_monitor_en_i) begin
         next_osc_en[`CSW_SRC_LOW_POWER_RC] = 1'b1;
      end
      if (secondary_osc_enable) begin
         next_osc_en[`CSW_SRC_SEC] = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Reference output
   // ---------------------------------------------------------------
   assign ref_run = ref_out_enable &&
                    (!sleep_i || (ref_run_in_sleep && ref_source_select &&
                                  is_primary(current_source_sel)));

   csw_ref_div u_div (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .base_i (ref_source_select ? primary_clk_i : system_clk_i),
      .div_i  (ref_divisor),
      .run_i  (ref_run),
      .out_o  (ref_div_out)
   );

   always @(posedge clk_i) begin
      if (rst_i) begin
         sys_src_sel_o   <= 3'h0;
         osc_enable_o    <= 8'h00;
         switch_busy_o   <= 1'b0;
         ref_clock_pin_o <= 1'b0;
      end else begin
         sys_src_sel_o   <= current_source_sel;
         osc_enable_o    <= next_osc_en;
         switch_busy_o   <= (state != S_IDLE);
         ref_clock_pin_o <= ref_div_out & ref_run;
      end
   end

endmodule // csw_ctrl

// ### bench/csw_ctrl_properties.sv
// Purpose: Port-level checks of the clock switch block
// Assumes: Bound into csw_ctrl, one clock domain
// Notes:   Mirrors reference control bits 15:8 from completed bus writes
`timescale 1ns/1ps
`include "csw_regs.vh"
module csw_ctrl_properties (
   input wire        clk_i,
   input wire        rst_i,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [3:0]  wb_adr_i,
   input wire [3:0]  wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        switch_config_bit_i,
   input wire [2:0]  config_initial_source_i,
   input wire        new_clk_tick_i,
   input wire        sleep_i,
   input wire [2:0]  sys_src_sel_o,
   input wire        switch_busy_o,
   input wire        ref_clock_pin_o
);
   reg [7:0] ref_hi;
   reg [3:0] ticks;
   always @(posedge clk_i) begin
      if (rst_i) begin
         ref_hi <= 8'h00;
         ticks  <= 4'h0;
      end else begin
         if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == `CSW_ADR_REF
             && wb_sel_i[1])
            ref_hi <= wb_dat_i[15:8];
         ticks <= switch_busy_o ? ticks + {3'h0, new_clk_tick_i} : 4'h0;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'hc
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   a_ref_rsvd_zero: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == `CSW_ADR_REF |-> wb_dat_o[14] == 1'b0
      && wb_dat_o[7:0] == 8'h00) else $error("reserved reference bits set");
   a_src_after_ticks: assert property (!switch_config_bit_i && $changed(sys_src_sel_o)
      |-> ticks == 4'ha && $past(switch_busy_o)) else $error("handover count");
   a_disabled_follow: assert property (
      (switch_config_bit_i && $stable(config_initial_source_i))[*3]
      |-> sys_src_sel_o == config_initial_source_i) else $error("configured source");
   a_ref_off_low: assert property ((!ref_hi[7])[*3] |-> !ref_clock_pin_o)
      else $error("reference pin active while off");
   a_sleep_stops: assert property ((sleep_i && !ref_hi[5])[*4]
      |-> $stable(ref_clock_pin_o)) else $error("reference runs in sleep");
   c_switch_done: cover property ($fell(switch_busy_o));
   c_ref_toggle: cover property (ref_hi[7] && $changed(ref_clock_pin_o));
   c_disabled: cover property (switch_config_bit_i && wb_ack_o);
endmodule // csw_ctrl_properties
bind csw_ctrl csw_ctrl_properties u_props (.*);

// ### bench/clock_switch_and_ref_out_tb_top.sv
// Purpose: Self-checking bench of the clock switch block
// Assumes: Classic Wishbone tasks, random data from seed 10
// Notes:   System clock toggles each cycle and primary clock while pri_run is set, so divide code n toggles every 2^n cycles
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error %0t: got %0h want %0h", $time, (g), (e)); end end
module clock_switch_and_ref_out_tb_top;
   reg         clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   reg         switch_config_bit_i = 0, failsafe_monitor_en_i = 0, watchdog_en_i = 0;
   reg         clock_fail_i = 0, pll_lock_i = 0, new_clk_tick_i = 0, sleep_i = 0;
   reg         primary_clk_i = 0, system_clk_i = 0, pri_run = 0;
   reg [3:0]   wb_adr_i = 0, wb_sel_i = 0;
   reg [31:0]  wb_dat_i = 0, rd;
   reg [2:0]   config_initial_source_i = 0, cur = 0;
   reg [7:0]   osc_ready_i = 0;
   wire [31:0] wb_dat_o;
   wire        wb_ack_o, switch_busy_o, ref_clock_pin_o;
   wire [2:0]  sys_src_sel_o;
   wire [7:0]  osc_enable_o;
   int         error_cnt = 0, comparisons = 0, t, i, e;
   int         seq [10] = '{2, 3, 0, 1, 0, 4, 5, 7, 7, 2};
   int         rv [11] = '{'h8000, 'h8100, 'h8200, 'h8300, 'h8400, 'h9100, 'h9100,
                           'hb100, 'h9100, 'ha100, 'h3100};
   int         md [11] = '{0, 0, 0, 0, 0, 0, 2, 3, 3, 3, 2};

   // Expected pin toggles in 64 cycles; system clock toggles every cycle, primary clock only while pri_run is set
   function automatic int exp_tog(input int r, input int m, input reg [2:0] c);
      if (!r[15] || (r[12] && !m[1])) return 0;
      if (m[0] && !(r[13] && r[12] && c[2:1] == 2'b01)) return 0;
      return 64 >> r[11:8];
   endfunction

   csw_ctrl u_dut (.*);

   initial forever #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      system_clk_i  <= ~system_clk_i;
      primary_clk_i <= pri_run & ~primary_clk_i;
   end

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic wb(input reg w, input reg [3:0] a, s, input reg [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, s, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         $display("Error %0t: no ack", $time);
         wrap_up;
      end
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask

   task automatic unl(input reg [2:0] n);
      wb(1, 0, 2, 32'h7800);
      wb(1, 0, 2, 32'h9a00);
      wb(1, 0, 2, {21'h0, n, 8'h00});
      wb(1, 0, 1, 32'h46);
      wb(1, 0, 1, 32'h57);
      wb(1, 0, 1, 32'h01);
   endtask

   task automatic swtch(input reg [2:0] n);
      int k;
      osc_ready_i  <= 8'h01 << cur;
      pll_lock_i   <= 0;
      clock_fail_i <= 1;
      @(posedge clk_i) clock_fail_i <= 0;
      wb(0, 0, 3, 0);
      `CHK(rd[3], 1'b1)
      unl(n);
      repeat ($urandom_range(6, 2)) @(posedge clk_i);
      wb(0, 0, 3, 0);
      if (n == cur) begin
         `CHK({switch_busy_o, rd[0], sys_src_sel_o}, {2'b00, cur})
      end else begin
         `CHK({switch_busy_o, osc_enable_o[n], rd[5], rd[3]}, 4'b1100)
         osc_ready_i[n] <= 1;
         if (n == 1 || n == 3) begin
            repeat (4) @(posedge clk_i);
            `CHK(switch_busy_o, 1'b1)
            wb(0, 0, 3, 0);
            `CHK({rd[0], rd[5]}, 2'b10)
            pll_lock_i <= 1;
         end
         for (k = 0; k < 10; k++) begin
            @(negedge clk_i) `CHK(sys_src_sel_o, cur)
            @(posedge clk_i) new_clk_tick_i <= 1;
            @(posedge clk_i) new_clk_tick_i <= 0;
         end
         wb(0, 0, 3, 0);
         `CHK({rd[14:12], rd[10:8], rd[0], switch_busy_o}, {n, n, 2'b00})
         `CHK(osc_enable_o[cur], 1'b0)
         cur = n;
      end
   endtask

   task automatic toggles(output int c);
      reg p;
      c = 0;
      repeat (8) @(negedge clk_i);
      p = ref_clock_pin_o;
      repeat (64) begin
         @(negedge clk_i);
         c += (ref_clock_pin_o !== p);
         p = ref_clock_pin_o;
      end
      @(posedge clk_i);
   endtask

   initial begin
      i = $urandom(10);
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      wb(0, 4, 4'hf, 0);
      `CHK({rd, sys_src_sel_o}, 35'h0)
      for (t = 0; t < 2; t++) begin
         wb(1, 0, 2, 32'h7800);
         if (t == 0) wb(0, 0, 3, 0);
         wb(1, 0, 2, 32'h9a00);
         if (t == 1) wb(0, 0, 3, 0);
         wb(1, 0, 2, 32'h0200);
         wb(1, 0, 1, 32'h01);
         repeat (3) @(posedge clk_i);
         wb(0, 0, 3, 0);
         `CHK({rd[10:8], rd[0], switch_busy_o}, 5'h0)
      end
      $display("key sequence test done");
      for (i = 0; i < 6; i++) begin
         t = $urandom;
         wb(1, i < 5 ? 4'h4 : 4'hc, 4'hf, t);
         wb(0, i < 5 ? 4'h4 : 4'hc, 4'hf, 0);
         `CHK(rd, i < 5 ? t & 32'hbf00 : 32'h0)
      end
      $display("register test done");
      for (i = 0; i < 10; i++) swtch(seq[i]);
      $display("switch test done");
      for (i = 0; i < 11; i++) begin
         {pri_run, sleep_i} <= md[i][1:0];
         wb(1, 4, 2, rv[i]);
         toggles(t);
         e = exp_tog(rv[i], md[i], cur);
         `CHK(t >= e - 1 && t <= e + 1, 1'b1)
      end
      `CHK(ref_clock_pin_o, 1'b0)
      $display("reference output test done");
      {watchdog_en_i, failsafe_monitor_en_i} <= 2'b10;
      wb(1, 0, 1, 32'h82);
      wb(0, 0, 3, 0);
      `CHK({rd[7], rd[1], osc_enable_o[5:4]}, 4'hf)
      {watchdog_en_i, failsafe_monitor_en_i} <= 2'b01;
      unl(3'h0);
      repeat (3) @(posedge clk_i);
      wb(0, 0, 3, 0);
      `CHK({rd[7], rd[0], switch_busy_o, osc_enable_o[5]}, 4'h9)
      $display("selection lock test done");
      sleep_i                 <= 0;
      config_initial_source_i <= 3'h5;
      switch_config_bit_i     <= 1;
      repeat (4) @(posedge clk_i);
      unl(3'h2);
      repeat (3) @(posedge clk_i);
      wb(0, 0, 3, 0);
      `CHK({sys_src_sel_o, rd[14:12], rd[0], switch_busy_o}, 8'hb4)
      $display("disabled switching test done");
      wrap_up;
   end
endmodule // clock_switch_and_ref_out_tb_top
